/* common/ric_pkg.sv */
// package for the reset and interrupt controller
package ric_pkg;

	// register map (byte addresses, one word each)
	localparam logic [11:0] MISC_CTRL_OFS   = 12'h00c;
	localparam logic [11:0] CORE_IF_OFS     = 12'h010;
	localparam logic [11:0] STATUS_OFS      = 12'h014;

	// misc_interrupt_reset_control field positions
	localparam int KEYPAD_MASTER_EN_BIT   = 7;
	localparam int KEYPAD_CLR_BIT         = 6;
	localparam int TRIGGER_EDGE_BIT       = 5;
	localparam int EXT_INT_EN_BIT         = 4;
	localparam int SUPPLY_DROP_EN_BIT     = 3;
	localparam int SLOW_CLOCK_SEL_BIT     = 2;
	localparam int SECOND_CLR_BIT         = 1;
	localparam int SECOND_EN_BIT          = 0;
	localparam logic [7:0] MISC_CTRL_RESET = 8'h10;
	// write-only bits always read zero
	localparam logic [7:0] MISC_CTRL_RMASK = 8'hbd;

	// core interface register fields
	localparam int GLOBAL_MASK_BIT  = 0;
	localparam int TRAP_REQ_BIT     = 1;
	localparam int INT_ACK_BIT      = 2;
	localparam int TRAP_RETURN_BIT  = 3;
	localparam int TIMER_MASK_BIT   = 4;

	// vector addresses (high byte of each pair)
	localparam logic [15:0] VEC_RESET   = 16'h1ffe;
	localparam logic [15:0] VEC_TRAP    = 16'h1ffc;
	localparam logic [15:0] VEC_EXT1    = 16'h1ffa;
	localparam logic [15:0] VEC_EXT2    = 16'h1ff8;
	localparam logic [15:0] VEC_TIMER   = 16'h1ff6;
	localparam logic [15:0] VEC_KEYPAD  = 16'h1ff4;

	// power-up settle count in bus cycles (plain default)
	localparam int POWER_UP_SETTLE_COUNT = 4064;
	// minimum external reset low, tenths of an instruction cycle
	localparam int EXT_RESET_MIN_TENTHS = 15;

	// service source; SRC_EXT1 to SRC_KEYPAD in priority order, trap picked below them
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_RESET,
		SRC_TRAP,
		SRC_EXT1,
		SRC_EXT2,
		SRC_TIMER,
		SRC_KEYPAD
	} ric_src_t;

	// request toward the core
	typedef struct packed {
		logic        valid;
		ric_src_t    src;
		logic [15:0] vector;
	} ric_req_t;

endpackage : ric_pkg

/* src/ric_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module ric_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin_in,
	output var  logic level_out
);
	logic [2:0] stage_q;
	logic       level_q;

	// shift the pin through three flops
	always_ff @(posedge clk) begin
		if (srst) begin
			stage_q <= {3{RESET_VAL}};
		end else begin
			stage_q <= {stage_q[1:0], pin_in};
		end
	end

	// accept a change once stages two and three agree
	always_ff @(posedge clk) begin
		if (srst) begin
			level_q <= RESET_VAL;
		end else if (stage_q[1] == stage_q[2]) begin
			level_q <= stage_q[2];
		end
	end

	assign level_out = level_q;
endmodule : ric_sync
`default_nettype wire

/* src/ric_top.sv */
// reset and interrupt controller with apb registers
`timescale 1ns/10ps
`default_nettype none
module ric_top
	import ric_pkg::*;
#(
	parameter int SETTLE_COUNT = POWER_UP_SETTLE_COUNT
) (
	input  wire logic             clk,
	input  wire logic             srst,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output var  logic [31:0]      prdata,
	output var  logic             pready,
	output var  logic             pslverr,
	// reset pin as three signals: input and drive level active low, output enable active high
	input  wire logic             reset_pin_in_n,
	output var  logic             reset_pin_out_n,
	output var  logic             reset_pin_oe,
	// sources
	input  wire logic             supply_drop_reset,
	input  wire logic             ext_int_pin_n,
	input  wire logic             port_d_bit_six,
	input  wire logic             timer_overflow_flag,
	input  wire logic             keypad_interrupt,
	// core side
	input  wire logic             instr_boundary,
	output var  logic             core_reset,
	output var  ric_pkg::ric_req_t core_req,
	output var  logic             keypad_latch_clear,
	output var  logic             slow_clock_select
);
	import ric_pkg::*;

	// refuse a settle count the counter cannot serve
	if (SETTLE_COUNT < 1) begin : g_bad_settle
		$error("settle count must be positive");
	end

	localparam int CW = $clog2(SETTLE_COUNT + 1);

	logic          rst_pin_n;
	logic          ext_pin_n;
	logic          d6_pin_n;
	logic [CW-1:0] settle_q;
	logic          settling_q;
	logic          core_reset_q;
	logic          drive_low_q;
	logic [7:0]    misc_q;
	logic          gmask_q;
	logic          tmask_q;
	logic          trap_pend_q;
	logic          ext1_latch_q;
	logic          ext2_latch_q;
	logic          ext1_prev_q;
	logic          ext2_prev_q;
	logic          keypad_latch_q;
	logic          kclr_q;
	ric_req_t      req_q;
	logic [31:0]   prdata_q;
	logic          pready_q;
	logic          pslverr_q;

	// pin synchronisers
	ric_sync #(.RESET_VAL(1'b1)) u_sync_rst (
		.clk       (clk),
		.srst      (srst),
		.pin_in    (reset_pin_in_n),
		.level_out (rst_pin_n)
	);
	ric_sync #(.RESET_VAL(1'b1)) u_sync_ext1 (
		.clk       (clk),
		.srst      (srst),
		.pin_in    (ext_int_pin_n),
		.level_out (ext_pin_n)
	);
	ric_sync #(.RESET_VAL(1'b1)) u_sync_ext2 (
		.clk       (clk),
		.srst      (srst),
		.pin_in    (port_d_bit_six),
		.level_out (d6_pin_n)
	);

	// apb decode
	wire apb_setup  = psel && !penable;
	wire apb_wr     = psel && penable && pwrite && pready_q;
	wire hit_misc   = (paddr == MISC_CTRL_OFS);
	wire hit_core   = (paddr == CORE_IF_OFS);
	wire hit_status = (paddr == STATUS_OFS);
	wire hit_any    = hit_misc || hit_core || hit_status;
	wire wr_misc    = apb_wr && hit_misc;
	wire wr_core    = apb_wr && hit_core;

	// reset merge: power-up settle, pin, enabled supply drop
	wire drop_rst   = supply_drop_reset
		&& misc_q[SUPPLY_DROP_EN_BIT];
	wire any_reset  = settling_q || !rst_pin_n || drop_rst;

	// power-up settle counter, starts on srst release
	always_ff @(posedge clk) begin
		if (srst) begin
			settle_q   <= '0;
			settling_q <= 1'b1;
		end else if (settling_q) begin
			settle_q   <= settle_q + CW'(1);
			settling_q <= (settle_q != CW'(SETTLE_COUNT - 1));
		end
	end

	// registered reset and pin drive
	always_ff @(posedge clk) begin
		if (srst) begin
			core_reset_q <= 1'b1;
			drive_low_q  <= 1'b1;
		end else begin
			core_reset_q <= any_reset;
			drive_low_q  <= settling_q;
		end
	end

	// edge detectors on filtered pins
	wire ext1_fall  = ext1_prev_q && !ext_pin_n;
	wire ext2_fall  = ext2_prev_q && !d6_pin_n;
	wire edge_mode  = misc_q[TRIGGER_EDGE_BIT];
	wire ext1_en    = misc_q[EXT_INT_EN_BIT];
	wire ext2_en    = misc_q[SECOND_EN_BIT];

	// first external request: level tracks pin, edge uses latch
	wire ext1_req   = ext1_en && (edge_mode ? ext1_latch_q
		: !ext_pin_n);
	wire ext2_req   = ext2_en && ext2_latch_q;
	wire timer_req  = timer_overflow_flag && !tmask_q;
	wire key_req    = misc_q[KEYPAD_MASTER_EN_BIT]
		&& keypad_latch_q;
	wire hw_any     = ext1_req || ext2_req || timer_req || key_req;

	// core control writes
	wire ack_w      = wr_core && pwdata[INT_ACK_BIT];
	wire ret_w      = wr_core && pwdata[TRAP_RETURN_BIT];
	wire trap_w     = wr_core && pwdata[TRAP_REQ_BIT];

	// priority pick when an instruction completes
	ric_src_t pick_src;
	logic [15:0] pick_vec;
	always_comb begin
		pick_src = SRC_NONE;
		pick_vec = VEC_RESET;
		if (!gmask_q && hw_any) begin
			if (ext1_req) begin
				pick_src = SRC_EXT1;
				pick_vec = VEC_EXT1;
			end else if (ext2_req) begin
				pick_src = SRC_EXT2;
				pick_vec = VEC_EXT2;
			end else if (timer_req) begin
				pick_src = SRC_TIMER;
				pick_vec = VEC_TIMER;
			end else begin
				pick_src = SRC_KEYPAD;
				pick_vec = VEC_KEYPAD;
			end
		end else if (trap_pend_q) begin
			pick_src = SRC_TRAP;
			pick_vec = VEC_TRAP;
		end
	end

	// trap pending: taken regardless of mask
	wire trap_taken = instr_boundary && !req_q.valid
		&& (pick_src == SRC_TRAP);

	always_ff @(posedge clk) begin
		if (srst || core_reset_q) begin
			trap_pend_q <= 1'b0;
		end else if (trap_w) begin
			trap_pend_q <= 1'b1;
		end else if (trap_taken) begin
			trap_pend_q <= 1'b0;
		end
	end

	// request issue: at instruction boundary, reset request on reset
	always_ff @(posedge clk) begin
		if (srst || core_reset_q) begin
			req_q <= '{valid: 1'b1, src: SRC_RESET,
				vector: VEC_RESET};
		end else if (req_q.valid) begin
			if (ack_w) begin
				req_q <= '{valid: 1'b0, src: SRC_NONE,
					vector: VEC_RESET};
			end
		end else if (instr_boundary && pick_src != SRC_NONE) begin
			req_q <= '{valid: 1'b1, src: pick_src,
				vector: pick_vec};
		end
	end

	// global and timer masks
	always_ff @(posedge clk) begin
		if (srst || core_reset_q) begin
			gmask_q <= 1'b1;
			tmask_q <= 1'b1;
		end else if (wr_core) begin
			gmask_q <= pwdata[GLOBAL_MASK_BIT] || ack_w;
			tmask_q <= pwdata[TIMER_MASK_BIT];
		end else if (instr_boundary && !req_q.valid
			&& pick_src != SRC_NONE) begin
			gmask_q <= 1'b1;
		end
	end

	// acknowledge of an external source clears its latch
	wire ack_ext1 = ack_w && req_q.src == SRC_EXT1;
	wire clr2     = (wr_misc && pwdata[SECOND_CLR_BIT])
		|| (ack_w && req_q.src == SRC_EXT2);

	// edge latches; a set in the clear cycle wins
	always_ff @(posedge clk) begin
		if (srst || core_reset_q) begin
			ext1_latch_q   <= 1'b0;
			ext2_latch_q   <= 1'b0;
			keypad_latch_q <= 1'b0;
			ext1_prev_q    <= 1'b1;
			ext2_prev_q    <= 1'b1;
		end else begin
			ext1_prev_q    <= ext_pin_n;
			ext2_prev_q    <= d6_pin_n;
			ext1_latch_q   <= (ext1_fall && edge_mode && ext1_en)
				|| (ext1_latch_q && !ack_ext1);
			ext2_latch_q   <= (ext2_fall && ext2_en)
				|| (ext2_latch_q && !clr2);
			keypad_latch_q <= keypad_interrupt
				|| (keypad_latch_q && !(wr_misc
				&& pwdata[KEYPAD_CLR_BIT]));
		end
	end

	// misc control register; clear bits stay zero
	// supply drop enable survives its own reset so a drop holds reset
	always_ff @(posedge clk) begin
		if (srst) begin
			misc_q <= MISC_CTRL_RESET;
			kclr_q <= 1'b0;
		end else if (core_reset_q) begin
			misc_q <= MISC_CTRL_RESET;
			misc_q[SUPPLY_DROP_EN_BIT] <= misc_q[SUPPLY_DROP_EN_BIT];
			kclr_q <= 1'b0;
		end else begin
			kclr_q <= wr_misc && pwdata[KEYPAD_CLR_BIT];
			if (wr_misc) begin
				misc_q <= pwdata[7:0] & MISC_CTRL_RMASK;
			end
		end
	end

	// read mux
	wire [31:0] rd_mux =
		hit_misc ? {24'h000000, misc_q & MISC_CTRL_RMASK} :
		hit_core ? {27'h0, tmask_q, 2'b00, trap_pend_q, gmask_q} :
		hit_status ? {21'h0, req_q.vector[10:0]} ^
			{21'h0, 11'h000} | {24'h0, ext1_latch_q, ext2_latch_q,
			keypad_latch_q, hw_any, 1'b0, req_q.src} :
		32'h00000000;

	// apb answer: no wait state, error on unmapped
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup && !hit_any;
			if (apb_setup && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// outputs from flops, pin drive level tied low
	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign reset_pin_out_n    = 1'b0;
	assign reset_pin_oe       = drive_low_q;
	assign core_reset         = core_reset_q;
	assign core_req           = req_q;
	assign keypad_latch_clear = kclr_q;
	assign slow_clock_select  = misc_q[SLOW_CLOCK_SEL_BIT];
endmodule : ric_top
`default_nettype wire

/* tb/ric_core_model.sv */
// core model: instruction ends and reset pin wire
`timescale 1ns/10ps
`default_nettype none
module ric_core_model (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic ext_rst_n,
	input  wire logic reset_pin_out_n,
	input  wire logic reset_pin_oe,
	output var  logic reset_pin_in_n,
	output var  logic instr_boundary
);
	logic [1:0] cyc_q;
	// one instruction completes every fourth cycle
	always_ff @(posedge clk) begin
		cyc_q <= srst ? 2'h0 : cyc_q + 2'h1;
		instr_boundary <= (cyc_q == 2'h3);
	end
	// pin pulled up, low when either party drives it
	assign reset_pin_in_n = ext_rst_n && (!reset_pin_oe || reset_pin_out_n);
endmodule : ric_core_model
`default_nettype wire

/* tb/ric_sva.sv */
// port assertions for the reset and interrupt controller
`timescale 1ns/10ps
`default_nettype none
module ric_sva
	import ric_pkg::*;
#(
	parameter int SETTLE_COUNT = POWER_UP_SETTLE_COUNT
) (
	input wire logic              clk,
	input wire logic              srst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              reset_pin_in_n,
	input wire logic              reset_pin_oe,
	input wire logic              instr_boundary,
	input wire logic              core_reset,
	input wire ric_pkg::ric_req_t core_req,
	input wire logic              keypad_latch_clear
);
	logic [15:0] oe_q;
	logic [3:0]  lo_q;
	// access-phase decodes
	wire logic acc_w = psel && penable && pready;
	wire logic ack_w = acc_w && pwrite && paddr == CORE_IF_OFS
		&& pwdata[INT_ACK_BIT];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// settle length and pin-low run counters
	always_ff @(posedge clk) begin
		oe_q <= (srst || !reset_pin_oe) ? 16'h0 : oe_q + 16'h1;
		lo_q <= reset_pin_in_n ? 4'h0 : lo_q + {3'h0, lo_q != 4'hf};
	end
	sequence misc_read;
		acc_w && !pwrite && paddr == MISC_CTRL_OFS;
	endsequence
	sequence kclr_write;
		acc_w && pwrite && paddr == MISC_CTRL_OFS && pwdata[KEYPAD_CLR_BIT];
	endsequence
	chk_reset_vector: assert property ($fell(srst) |-> core_reset
		&& core_req.valid && core_req.vector == VEC_RESET)
		else $error("reset vector wrong");
	chk_pin_driven: assert property ($fell(srst) |-> reset_pin_oe[*4])
		else $error("pin not driven low");
	chk_settle_len: assert property ($fell(reset_pin_oe)
		|-> oe_q >= SETTLE_COUNT - 1)
		else $error("settle too short");
	chk_pin_holds: assert property (lo_q >= 4'h8 |-> core_reset)
		else $error("reset left with pin low");
	chk_release_clean: assert property ($fell(core_reset)
		|-> !reset_pin_oe && $past(reset_pin_in_n))
		else $error("reset released early");
	chk_at_boundary: assert property ($rose(core_req.valid)
		&& core_req.src != SRC_RESET |-> $past(instr_boundary))
		else $error("request off boundary");
	chk_vector_map: assert property (core_req.valid |->
		core_req.vector == 16'h2000 - {12'h0, core_req.src, 1'b0})
		else $error("vector mismatch");
	chk_req_stands: assert property (core_req.valid && !ack_w
		&& !core_reset |=> core_req.valid && $stable(core_req.src))
		else $error("request dropped");
	chk_ack_drops: assert property (ack_w && !core_reset
		|=> !core_req.valid)
		else $error("ack ignored");
	chk_wo_zero: assert property (misc_read |->
		prdata[31:8] == 24'h0 && !prdata[1] && !prdata[6])
		else $error("write-only bit read");
	chk_keypad_clear: assert property (kclr_write
		|-> ##[1:2] keypad_latch_clear)
		else $error("keypad clear missing");
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no pready");
endmodule : ric_sva
bind ric_top ric_sva #(.SETTLE_COUNT(SETTLE_COUNT)) ric_sva_i (.*);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the reset and interrupt controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ric_pkg::*;
	logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, err, pready, pslverr, reset_pin_in_n;
	logic        reset_pin_out_n, reset_pin_oe, ext_rst_n = 1'b1;
	logic        supply_drop_reset = 1'b0, ext_int_pin_n = 1'b1;
	logic        port_d_bit_six = 1'b1, timer_overflow_flag = 1'b0;
	logic        keypad_interrupt = 1'b0, instr_boundary, core_reset;
	logic        keypad_latch_clear, slow_clock_select;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	ric_req_t    core_req;
	int          fails = 0, total_checks = 0;
	ric_top #(.SETTLE_COUNT(8)) ric_top_i (.*);
	ric_core_model ric_core_model_i (.*);
	always #10 clk = !clk;
	task automatic give_verdict;
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wc(input logic [7:0] d);
		apb(1'b1, CORE_IF_OFS, {24'h0, d});
	endtask : wc
	task automatic wm(input logic [7:0] d);
		apb(1'b1, MISC_CTRL_OFS, {24'h0, d});
	endtask : wm
	task automatic pause;
		repeat (8) @(posedge clk);
	endtask : pause
	// wait for a request, check it, acknowledge
	task automatic expect_req(input ric_src_t s, input logic un);
		repeat (40) if (core_req.valid !== 1'b1) @(posedge clk);
		chk(32'({core_req.src, core_req.vector}),
			32'({s, 16'h2000 - {s, 1'b0}}));
		wc(8'h15);
		if (un)
			wc(8'h10);
	endtask : expect_req
	task automatic expect_none;
		repeat (12) @(posedge clk);
		chk(32'(core_req.valid), 32'h0);
	endtask : expect_none
	task automatic rst_done(input logic [7:0] m);
		repeat (60) if (core_reset !== 1'b0) @(posedge clk);
		apb(1'b0, MISC_CTRL_OFS, 32'h0);
		chk(rd, {24'h0, m});
		expect_req(SRC_RESET, 1'b1);
	endtask : rst_done
	task automatic t_level;
		wc(8'h11);
		ext_int_pin_n <= 1'b0;
		expect_none;
		wc(8'h10);
		expect_req(SRC_EXT1, 1'b1);
		expect_req(SRC_EXT1, 1'b0);
		ext_int_pin_n <= 1'b1;
		pause;
		wc(8'h10);
		expect_none;
	endtask : t_level
	task automatic t_edge;
		wm(8'h30);
		wc(8'h11);
		ext_int_pin_n <= 1'b0;
		pause;
		wc(8'h10);
		expect_req(SRC_EXT1, 1'b1);
		expect_none;
		ext_int_pin_n <= 1'b1;
		pause;
	endtask : t_edge
	task automatic t_second;
		wm(8'h10);
		port_d_bit_six <= 1'b0;
		expect_none;
		port_d_bit_six <= 1'b1;
		wm(8'h11);
		pause;
		port_d_bit_six <= 1'b0;
		expect_req(SRC_EXT2, 1'b0);
		port_d_bit_six <= 1'b1;
		pause;
		port_d_bit_six <= 1'b0;
		pause;
		wm(8'h13);
		apb(1'b0, MISC_CTRL_OFS, 32'h0);
		chk(rd, 32'h11);
		wc(8'h10);
		expect_none;
		port_d_bit_six <= 1'b1;
	endtask : t_second
	task automatic t_prio;
		wm(8'h90);
		wc(8'h11);
		ext_int_pin_n <= 1'b0;
		timer_overflow_flag <= 1'b1;
		keypad_interrupt <= 1'b1;
		pause;
		keypad_interrupt <= 1'b0;
		wc(8'h00);
		expect_req(SRC_EXT1, 1'b0);
		ext_int_pin_n <= 1'b1;
		pause;
		wc(8'h00);
		expect_req(SRC_TIMER, 1'b0);
		wc(8'h10);
		expect_req(SRC_KEYPAD, 1'b0);
		timer_overflow_flag <= 1'b0;
		wm(8'hd0);
		wc(8'h10);
		expect_none;
		wc(8'h13);
		expect_req(SRC_TRAP, 1'b1);
	endtask : t_prio
	task automatic t_resets;
		supply_drop_reset <= 1'b1;
		pause;
		chk(32'(core_reset), 32'h0);
		wm(8'h18);
		pause;
		chk(32'(core_reset), 32'h1);
		supply_drop_reset <= 1'b0;
		rst_done(8'h18);
		srst <= 1'b1;
		ext_rst_n <= 1'b0;
		pause;
		srst <= 1'b0;
		repeat (20) @(posedge clk);
		chk(32'(core_reset), 32'h1);
		ext_rst_n <= 1'b1;
		rst_done(8'h10);
	endtask : t_resets
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(reset_pin_oe), 32'h1);
		rst_done(8'h10);
		apb(1'b0, 12'h020, 32'h0);
		chk(32'(err), 32'h1);
		t_level;
		t_edge;
		t_second;
		t_prio;
		t_resets;
		give_verdict;
	end
	// watchdog against a hang
	initial begin
		repeat (6000) @(posedge clk);
		fails++;
		give_verdict;
	end
endmodule : testbench
`default_nettype wire
